// ### rtl/port_change_defs.vh
// Register map, field positions and reset values for the port change-detect block
// Overview of operation
// - Global enable clear: flag sets, no request
// - Watch pin only when its enable set
// - Port write also ends the mismatch
// - Persisting mismatch keeps setting the flag
// - Latch survives pin reset; flag re-sets
// - Change during port access may be missed
// - Change wakes from sleep when globally enabled
// - Port-A enables: eight R/W bits, reset zero
// - Port-A pin 5 off when reset input
// - Port-B enables: bit 3 unimplemented, reads zero
// - OR all enabled mismatches into one flag
// - Power-on reset disables all change detection
`ifndef PORT_CHANGE_DEFS_VH
`define PORT_CHANGE_DEFS_VH

`define ADDR_PORT_A_ENABLE  5'h00
`define ADDR_PORT_B_ENABLE  5'h04
`define ADDR_PORT_A_VALUE   5'h08
`define ADDR_PORT_B_VALUE   5'h0C
`define ADDR_CONTROL        5'h10

`define CTRL_FLAG_BIT       0
`define CTRL_GLOBAL_EN_BIT  1

`define ENABLE_RESET        8'h00
`define PORT_B_IMPL_MASK    8'hF7
`define PORT_A_PIN5         5

`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

// ### rtl/port_change_interrupt.v
// Interrupt-on-change detector for two 8-bit ports behind an AXI4-Lite slave
`include "port_change_defs.vh"

module port_change_interrupt
#(
    parameter WIDTH = 8
)
(
    input  wire             clock,
    input  wire             rst_n,
    input  wire             power_on_reset,
    input  wire             pin5_is_external_reset,
    input  wire [WIDTH-1:0] port_a_pins,
    input  wire [WIDTH-1:0] port_b_pins,
    output reg  [WIDTH-1:0] port_a_out,
    output reg  [WIDTH-1:0] port_b_out,
    output wire             change_irq,
    output wire             wake_request,
    input  wire [4:0]       s_axi_awaddr,
    input  wire             s_axi_awvalid,
    output wire             s_axi_awready,
    input  wire [31:0]      s_axi_wdata,
    input  wire [3:0]       s_axi_wstrb,
    input  wire             s_axi_wvalid,
    output wire             s_axi_wready,
    output reg  [1:0]       s_axi_bresp,
    output reg              s_axi_bvalid,
    input  wire             s_axi_bready,
    input  wire [4:0]       s_axi_araddr,
    input  wire             s_axi_arvalid,
    output wire             s_axi_arready,
    output reg  [31:0]      s_axi_rdata,
    output reg  [1:0]       s_axi_rresp,
    output reg              s_axi_rvalid,
    input  wire             s_axi_rready
);

    reg  [WIDTH-1:0] port_a_change_enable;
    reg  [WIDTH-1:0] port_b_change_enable;
    reg              change_flag;
    reg              change_irq_global_enable;
    reg  [WIDTH-1:0] sync_a_meta;
    reg  [WIDTH-1:0] sync_a;
    reg  [WIDTH-1:0] sync_b_meta;
    reg  [WIDTH-1:0] sync_b;
    reg  [WIDTH-1:0] last_a;
    reg  [WIDTH-1:0] last_b;
    reg  [4:0]       aw_addr;
    reg              aw_held;
    reg  [31:0]      w_data;
    reg  [3:0]       w_strb;
    reg              w_held;
    wire [WIDTH-1:0] watch_a;
    wire [WIDTH-1:0] watch_b;
    wire             mismatch;
    wire             do_write;
    wire             do_read;
    wire             port_access;
    wire             clear_flag;

    // Slot decodes shared by the write, read and flag logic
    wire             change_a;
    wire             change_b;
    wire             wr_byte0;
    wire             wr_a_enable;
    wire             wr_b_enable;
    wire             wr_a_value;
    wire             wr_b_value;
    wire             wr_control;
    wire             rd_a_enable;
    wire             rd_b_enable;
    wire             rd_a_value;
    wire             rd_b_value;
    wire             rd_control;
    wire             irq_level;
    reg  [1:0]       next_bresp;
    reg  [31:0]      next_rdata;
    reg  [1:0]       next_rresp;
    reg              next_change_flag;

    // Port B bit 3 has no pin behind it
    localparam [WIDTH-1:0] b_impl_mask = `PORT_B_IMPL_MASK;

    // Address match over the word-aligned map
    function is_addr;
        input [4:0] addr;
        input [4:0] target;
        begin
            is_addr = (addr[4:2] == target[4:2]);
        end
    endfunction

    // Any of the five word slots; everything else answers with an error
    function is_mapped;
        input [4:0] addr;
        begin
            is_mapped = is_addr(addr, `ADDR_PORT_A_ENABLE)
                      | is_addr(addr, `ADDR_PORT_B_ENABLE)
                      | is_addr(addr, `ADDR_PORT_A_VALUE)
                      | is_addr(addr, `ADDR_PORT_B_VALUE)
                      | is_addr(addr, `ADDR_CONTROL);
        end
    endfunction

    // Pins are two-flop synchronised; only the second stage is compared
    always @(posedge clock)
    begin
        sync_a_meta <= port_a_pins;
        sync_a      <= sync_a_meta;
    end

    // Port B follows the same two stages
    always @(posedge clock)
    begin
        sync_b_meta <= port_b_pins;
        sync_b      <= sync_b_meta;
    end

    // Pin 5 forced out of the watch set while it serves as reset input
    assign watch_a = port_a_change_enable
                   & ~({{(WIDTH-1){1'b0}}, pin5_is_external_reset} << `PORT_A_PIN5);
    assign watch_b = port_b_change_enable & b_impl_mask;

    // Each port compares its enabled pins with the last-read latch
    assign change_a = |((sync_a ^ last_a) & watch_a);
    assign change_b = |((sync_b ^ last_b) & watch_b);
    assign mismatch = change_a | change_b;

    // AXI write side: ready is combinational so a held channel blocks at once
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    // A write completes once both halves are held
    assign do_write      = aw_held & w_held & ~s_axi_bvalid;
    // One read in flight; a standing answer blocks the next address
    assign s_axi_arready = ~s_axi_rvalid;
    assign do_read       = s_axi_arvalid & s_axi_arready;

    // Write selects; every field sits in byte 0, so only that strobe counts
    assign wr_byte0    = do_write & w_strb[0];
    assign wr_a_enable = is_addr(aw_addr, `ADDR_PORT_A_ENABLE);
    assign wr_b_enable = is_addr(aw_addr, `ADDR_PORT_B_ENABLE);
    assign wr_a_value  = is_addr(aw_addr, `ADDR_PORT_A_VALUE);
    assign wr_b_value  = is_addr(aw_addr, `ADDR_PORT_B_VALUE);
    assign wr_control  = is_addr(aw_addr, `ADDR_CONTROL);

    // Read selects decode the address while it is offered
    assign rd_a_enable = is_addr(s_axi_araddr, `ADDR_PORT_A_ENABLE);
    assign rd_b_enable = is_addr(s_axi_araddr, `ADDR_PORT_B_ENABLE);
    assign rd_a_value  = is_addr(s_axi_araddr, `ADDR_PORT_A_VALUE);
    assign rd_b_value  = is_addr(s_axi_araddr, `ADDR_PORT_B_VALUE);
    assign rd_control  = is_addr(s_axi_araddr, `ADDR_CONTROL);

    // Any access to either value register ends the mismatch
    assign port_access = (do_read & (rd_a_value | rd_b_value))
                       | (do_write & (wr_a_value | wr_b_value));

    // Writing 0 to the flag bit clears it; writing 1 does nothing
    assign clear_flag = wr_byte0 & wr_control & ~w_data[`CTRL_FLAG_BIT];

    // Address and data are captured independently, in either order
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            aw_held <= 1'b0;
            aw_addr <= 5'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        else if (do_write)
            aw_held <= 1'b0;
    end

    // Data channel mirrors the address channel
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        else if (do_write)
            w_held <= 1'b0;
    end

    // Unmapped slots answer with an error and change nothing
    always @*
    begin
        if (is_mapped(aw_addr))
            next_bresp = `RESP_OKAY;
        else
            next_bresp = `RESP_SLVERR;
    end

    // Response stands until the master takes it
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= next_bresp;
        end
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Enable registers clear on power-on or bus reset
    always @(posedge clock)
    begin
        if (!rst_n || power_on_reset)
            port_a_change_enable <= `ENABLE_RESET;
        else if (wr_byte0 && wr_a_enable)
            port_a_change_enable <= w_data[WIDTH-1:0];
    end

    // Bit 3 is masked on write so it always reads back as zero
    always @(posedge clock)
    begin
        if (!rst_n || power_on_reset)
            port_b_change_enable <= `ENABLE_RESET;
        else if (wr_byte0 && wr_b_enable)
            port_b_change_enable <= w_data[WIDTH-1:0] & b_impl_mask;
    end

    // Global enable gates only the request; detection runs regardless
    always @(posedge clock)
    begin
        if (!rst_n || power_on_reset)
            change_irq_global_enable <= 1'b0;
        else if (wr_byte0 && wr_control)
            change_irq_global_enable <= w_data[`CTRL_GLOBAL_EN_BIT];
    end

    // Last-read latch has no reset term: it must survive a pin reset.
    // Until the first port access it is unknown, so software reads either port first.
    always @(posedge clock)
    begin
        if (port_access)
            last_a <= sync_a;
    end

    // Both latches reload together on any port access
    always @(posedge clock)
    begin
        if (port_access)
            last_b <= sync_b;
    end

    // Port output latches written through the value registers
    always @(posedge clock)
    begin
        if (!rst_n)
            port_a_out <= `ENABLE_RESET;
        else if (wr_byte0 && wr_a_value)
            port_a_out <= w_data[WIDTH-1:0];
    end

    // No pin behind port B bit 3, so it is held at zero
    always @(posedge clock)
    begin
        if (!rst_n)
            port_b_out <= `ENABLE_RESET;
        else if (wr_byte0 && wr_b_value)
            port_b_out <= w_data[WIDTH-1:0] & b_impl_mask;
    end

    // Set beats clear; a change in a port-access cycle is compared against
    // the fresh latch next cycle and so may be missed
    always @*
    begin
        next_change_flag = change_flag;
        if (mismatch && !port_access)
            next_change_flag = 1'b1;
        else if (clear_flag)
            next_change_flag = 1'b0;
    end

    // Bus reset clears the flag; it re-sets once the enables are rewritten if a mismatch remains
    always @(posedge clock)
    begin
        if (!rst_n)
            change_flag <= 1'b0;
        else
            change_flag <= next_change_flag;
    end

    // Request and wake share one level; the flag itself is never gated
    assign irq_level    = change_flag & change_irq_global_enable;
    assign change_irq   = irq_level;
    assign wake_request = irq_level;

    // Read data chosen from the selects; port reads return synchronised pins
    always @*
    begin
        next_rdata = 32'h0000_0000;
        next_rresp = `RESP_OKAY;
        if (rd_a_enable)
            next_rdata[WIDTH-1:0] = port_a_change_enable;
        else if (rd_b_enable)
            next_rdata[WIDTH-1:0] = port_b_change_enable;
        else if (rd_a_value)
            next_rdata[WIDTH-1:0] = sync_a;
        else if (rd_b_value)
            next_rdata[WIDTH-1:0] = sync_b & b_impl_mask;
        else if (rd_control)
        begin
            next_rdata[`CTRL_FLAG_BIT]      = change_flag;
            next_rdata[`CTRL_GLOBAL_EN_BIT] = change_irq_global_enable;
        end
        else
            next_rresp = `RESP_SLVERR;
    end

    // Read answer stands until the master takes it
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end
        else if (do_read)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule

// ### tb/pin_model.sv
// Far-side pin drivers for the two watched ports
module pin_model (
    input  wire logic       clock,
    input  wire logic [7:0] level_a,
    input  wire logic [7:0] level_b,
    output logic      [7:0] pins_a,
    output logic      [7:0] pins_b
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pins move just after an edge, so the design sync sees clean levels
    always @(posedge clock)
    begin
        pins_a <= level_a;
        pins_b <= level_b;
    end
endmodule

// ### tb/port_change_props.sv
// Port-level checks for the change-detect block
module port_change_props (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        change_irq,
    input wire logic        wake_request,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [4:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_wake_tracks_irq: assert property (wake_request == change_irq)
        else $error("wake differs from irq");
    a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read not answered");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_bit3_zero: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 5'h04 |=> !s_axi_rdata[3])
        else $error("unused enable bit reads one");
    a_reset_quiet: assert property ($rose(rst_n) |-> !s_axi_bvalid && !s_axi_rvalid && !change_irq)
        else $error("state left over after reset");
endmodule
bind port_change_interrupt port_change_props chk (.clock(clock), .rst_n(rst_n),
    .change_irq(change_irq), .wake_request(wake_request), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ### tb/port_change_interrupt_tb.sv
// Register-level tests of the change-detect block
module port_change_interrupt_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, rst_n = 0, power_on_reset = 1, pin5_is_external_reset = 0;
    logic [7:0] lvl_a = 0, lvl_b = 0;
    logic [4:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rd_data;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [1:0] rd_resp, wr_resp, bresp, rresp;
    wire [7:0] pa, pb, oa, ob;
    wire [31:0] rdata;
    wire change_irq, wake_request, awready, wready, bvalid, arready, rvalid;
    int n_mismatch = 0, total_checks = 0;
    always #20 clock = ~clock;
    pin_model far (.clock(clock), .level_a(lvl_a), .level_b(lvl_b), .pins_a(pa), .pins_b(pb));
    port_change_interrupt dut (.clock(clock), .rst_n(rst_n), .power_on_reset(power_on_reset),
        .pin5_is_external_reset(pin5_is_external_reset), .port_a_pins(pa), .port_b_pins(pb),
        .port_a_out(oa), .port_b_out(ob), .change_irq(change_irq), .wake_request(wake_request),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Ready is sampled at the falling edge, where it equals its value at the next rising edge
    task wr(input logic [4:0] a, input logic [31:0] d);
        logic ta, tw;
        @(posedge clock);
        ta = 0;
        tw = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(ta && tw))
        begin
            @(negedge clock);
            ta = ta | awready;
            tw = tw | wready;
            @(posedge clock);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
        end
        do @(negedge clock); while (!bvalid);
        wr_resp = bresp;
        @(posedge clock);
        bready <= 0;
    endtask
    task rd(input logic [4:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(negedge clock); while (!arready);
        @(posedge clock);
        arvalid <= 0;
        do @(negedge clock); while (!rvalid);
        rd_data = rdata;
        rd_resp = rresp;
        @(posedge clock);
        rready <= 0;
    endtask
    task rc(input logic [4:0] a, input logic [31:0] e);
        rd(a);
        chk(rd_data, e);
    endtask
    task irq(input logic e);
        @(negedge clock);
        chk({31'h0, change_irq}, {31'h0, e});
        @(posedge clock);
    endtask
    task final_report;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_mismatch++;
        final_report;
    end
    initial
    begin
        repeat (2) @(posedge clock);
        rst_n <= 1;
        power_on_reset <= 0;
        @(posedge clock);
        rc(5'h00, 32'h0000_0000);
        rc(5'h04, 32'h0000_0000);
        wr(5'h00, 32'h0000_00FF);
        rc(5'h00, 32'h0000_00FF);
        wr(5'h04, 32'h0000_00FF);
        rc(5'h04, 32'h0000_00F7);
        rc(5'h14, 32'h0000_0000);
        chk({30'h0, rd_resp}, 32'h0000_0002);
        rc(5'h08, 32'h0000_0000);
        wr(5'h10, 32'h0000_0002);
        pin5_is_external_reset <= 1;
        lvl_a <= 8'h20;
        lvl_b <= 8'h08;
        repeat (5) @(posedge clock);
        rc(5'h10, 32'h0000_0002);
        irq(1'b0);
        lvl_a <= 8'h21;
        repeat (4) @(posedge clock);
        rc(5'h10, 32'h0000_0003);
        irq(1'b1);
        wr(5'h10, 32'h0000_0002);
        rc(5'h10, 32'h0000_0003);
        rc(5'h08, 32'h0000_0021);
        wr(5'h10, 32'h0000_0002);
        rc(5'h10, 32'h0000_0002);
        lvl_b <= 8'h0A;
        repeat (4) @(posedge clock);
        rc(5'h10, 32'h0000_0003);
        wr(5'h0C, 32'h0000_005A);
        wr(5'h10, 32'h0000_0002);
        rc(5'h10, 32'h0000_0002);
        chk({24'h0, ob}, 32'h0000_0052);
        wr(5'h10, 32'h0000_0000);
        lvl_a <= 8'h23;
        repeat (4) @(posedge clock);
        rc(5'h10, 32'h0000_0001);
        irq(1'b0);
        rst_n <= 0;
        repeat (2) @(posedge clock);
        rst_n <= 1;
        @(posedge clock);
        wr(5'h00, 32'h0000_00FF);
        repeat (4) @(posedge clock);
        rc(5'h10, 32'h0000_0001);
        wr(5'h08, 32'h0000_00C3);
        chk({30'h0, wr_resp}, 32'h0000_0000);
        chk({24'h0, oa}, 32'h0000_00C3);
        wr(5'h10, 32'h0000_0000);
        rc(5'h10, 32'h0000_0000);
        wr(5'h14, 32'h0000_0001);
        chk({30'h0, wr_resp}, 32'h0000_0002);
        final_report;
    end
endmodule
